//--- dbms_top.v
`timescale 1ns/1ps
`default_nettype none
`include "dbms_defs.vh"

// Functional notes
// - Config bit 0 picks byte-mask pair or byte line plus grant acknowledge.
// - Mask encoding: 00 word, 01 upper byte, 10 lower byte, 11 none.
// - Mask lines driven only while master; never read as slave.
// - Byte-line style: byte line with latched address bit 0; low/high illegal.
// - Byte line driven only while master; ignored as slave.
// - Style 0: request whenever a cycle is needed and grant is inactive.
// - Request stays low for the whole ensuing bus transaction.
// - Config bit 1 picks strobe polarity: latch enable or inverted strobe.
// - Latch-enable polarity: high in address phase, low in data phase.
// - Low polarity: strobe pulses low during the address phase.
// - Strobe driven only while master, released otherwise.
// - Grant low answering our request makes the device bus master.
// - Config bit 6 turns pin 15 into a burst-release input ending the burst.
module dbms_top (
  input wire core_clk,
  input wire sys_rst,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  input wire xfer_valid,
  input wire xfer_more,
  input wire [1:0] xfer_byte_sel,
  input wire xfer_addr0,
  output reg xfer_done,
  output reg byte_mask_low_line,
  output reg byte_mask_low_line_oe,
  input wire burst_release_in,
  output reg byte_mask_high_line,
  output reg byte_mask_high_line_oe,
  output reg gated_bus_request,
  output reg gated_bus_request_oe,
  input wire gated_bus_request_in,
  input wire hold_grant_in,
  output reg addr_strobe_low,
  output reg addr_strobe_low_oe
);

  // ----------------------------------------------------------------
  // States and declarations
  // ----------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_REQ = 5'h02;
  localparam [4:0] ST_ADDR = 5'h04;
  localparam [4:0] ST_DATA = 5'h08;
  localparam [4:0] ST_REL = 5'h10;

  reg [4:0] state;
  reg [4:0] next_state;
  reg [1:0] cnt;
  reg [1:0] next_cnt;
  reg [7:0] bus_config_reg;
  reg [1:0] lat_sel;
  reg [1:0] next_lat_sel;
  reg lat_addr0;
  reg next_lat_addr0;
  reg grant_meta, grant_sync;
  reg rel_meta, rel_sync;
  reg reqpin_meta, reqpin_sync;
  reg release_pend, illegal_flag, relseen_flag;
  reg [15:0] xfer_count;
  wire bus_style_select, strobe_polarity_select, release_enable;
  wire release_hit, addr_end, data_end;
  wire master_next, addr_next, req_next;
  wire acc, wr_cfg, wr_status;
  wire start_xfer, illegal_now;
  wire [1:0] next_mask;

  assign bus_style_select = bus_config_reg[`DBMS_CFG_STYLE];
  assign strobe_polarity_select = bus_config_reg[`DBMS_CFG_POL];
  assign release_enable = bus_config_reg[`DBMS_CFG_REL];

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Mask pair {high, low} for a user byte code
  function [1:0] enc_mask;
    input [1:0] code;
    begin
      case (code)
        `DBMS_SEL_WORD: enc_mask = 2'h0;
        `DBMS_SEL_UPPER: enc_mask = 2'h1;
        `DBMS_SEL_LOWER: enc_mask = 2'h2;
        default: enc_mask = 2'h3;
      endcase
    end
  endfunction

  // Byte line is high for any single-byte transfer
  function byte_line;
    input [1:0] code;
    begin
      byte_line = (code != `DBMS_SEL_WORD);
    end
  endfunction

  // Combinations the byte-line scheme cannot express
  function line_illegal;
    input [1:0] code;
    input a0;
    begin
      line_illegal = (!byte_line(code) && a0) || (code == `DBMS_SEL_NONE);
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Grant and request pin idle high, so they reset to the inactive level
  always @(posedge core_clk) begin
    if (sys_rst) begin
      grant_meta <= 1'b1;
      grant_sync <= 1'b1;
      rel_meta <= 1'b0;
      rel_sync <= 1'b0;
      reqpin_meta <= 1'b1;
      reqpin_sync <= 1'b1;
    end else begin
      grant_meta <= hold_grant_in;
      grant_sync <= grant_meta;
      rel_meta <= burst_release_in;
      rel_sync <= rel_meta;
      reqpin_meta <= gated_bus_request_in;
      reqpin_sync <= reqpin_meta;
    end
  end

  assign release_hit = release_enable && rel_sync;

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  assign addr_end = (cnt == (`DBMS_ADDR_CYCLES - 2'h1));
  assign data_end = (cnt == (`DBMS_DATA_CYCLES - 2'h1));

  // Next state, phase counter and latched byte selection
  always @* begin
    next_state = state;
    next_cnt = cnt;
    next_lat_sel = lat_sel;
    next_lat_addr0 = lat_addr0;
    case (state)
      ST_IDLE: begin
        // level request, request gated by prior pin state
        if (xfer_valid && grant_sync && (!bus_style_select || reqpin_sync)) begin
          next_state = ST_REQ;
        end
      end
      ST_REQ: begin
        if (!grant_sync) begin
          next_state = ST_ADDR;
          next_cnt = 2'h0;
          next_lat_sel = xfer_byte_sel;
          next_lat_addr0 = xfer_addr0;
        end
      end
      ST_ADDR: begin
        if (addr_end) begin
          next_state = ST_DATA;
          next_cnt = 2'h0;
        end else begin
          next_cnt = cnt + 2'h1;
        end
      end
      ST_DATA: begin
        if (data_end) begin
          next_cnt = 2'h0;
          // burst ends after the current transfer
          if (xfer_more && !release_hit && !release_pend) begin
            next_state = ST_ADDR;
            next_lat_sel = xfer_byte_sel;
            next_lat_addr0 = xfer_addr0;
          end else begin
            next_state = ST_REL;
          end
        end else begin
          next_cnt = cnt + 2'h1;
        end
      end
      ST_REL: begin
        // wait for the arbiter to withdraw the grant
        if (grant_sync) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cnt = 2'h0;
      end
    endcase
  end

  // Sequencer registers
  always @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      cnt <= 2'h0;
      lat_sel <= `DBMS_SEL_WORD;
      lat_addr0 <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      lat_sel <= next_lat_sel;
      lat_addr0 <= next_lat_addr0;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  assign master_next = (next_state == ST_ADDR) || (next_state == ST_DATA);
  assign addr_next = (next_state == ST_ADDR);
  assign next_mask = enc_mask(next_lat_sel);
  // request held through the whole transaction
  assign req_next = master_next || (next_state == ST_REQ);

  // Outputs are registered from the next state so they line up with it
  always @(posedge core_clk) begin
    if (sys_rst) begin
      byte_mask_low_line <= 1'b1;
      byte_mask_low_line_oe <= 1'b0;
      byte_mask_high_line <= 1'b1;
      byte_mask_high_line_oe <= 1'b0;
      gated_bus_request <= 1'b0;
      gated_bus_request_oe <= 1'b0;
      addr_strobe_low <= 1'b0;
      addr_strobe_low_oe <= 1'b0;
    end else begin
      // Open drain: only ever pulls low
      gated_bus_request <= 1'b0;
      gated_bus_request_oe <= req_next;
      addr_strobe_low <= strobe_polarity_select ? !addr_next : addr_next;
      addr_strobe_low_oe <= master_next;
      // pin function by style; pin 15 turns input
      if (bus_style_select) begin
        // byte line with latched address bit, driven as master only
        byte_mask_low_line <= byte_line(next_lat_sel);
        // grant acknowledge follows mastership, always driven
        byte_mask_high_line <= master_next;
        byte_mask_high_line_oe <= 1'b1;
      end else begin
        // mask encoding, driven as master only
        byte_mask_low_line <= next_mask[0];
        byte_mask_high_line <= next_mask[1];
        byte_mask_high_line_oe <= master_next;
      end
      byte_mask_low_line_oe <= master_next && !release_enable;
    end
  end

  // ----------------------------------------------------------------
  // Burst bookkeeping
  // ----------------------------------------------------------------
  assign start_xfer = (next_state == ST_ADDR) && (state != ST_ADDR);
  assign illegal_now = start_xfer && bus_style_select &&
                       line_illegal(next_lat_sel, next_lat_addr0);
  assign acc = cyc_i && stb_i && !ack_o;
  assign wr_cfg = acc && we_i && sel_i[0] && (adr_i == `DBMS_ADR_CONFIG);
  assign wr_status = acc && we_i && sel_i[0] && (adr_i == `DBMS_ADR_STATUS);

  // Release is remembered mid-transfer; sticky flags let a set beat a clear
  always @(posedge core_clk) begin
    if (sys_rst) begin
      release_pend <= 1'b0;
      illegal_flag <= 1'b0;
      relseen_flag <= 1'b0;
      xfer_count <= 16'h0000;
      xfer_done <= 1'b0;
    end else begin
      if (state == ST_REL || state == ST_IDLE) begin
        release_pend <= 1'b0;
      end else if (release_hit && (state == ST_ADDR || state == ST_DATA)) begin
        release_pend <= 1'b1;
      end
      if (illegal_now) begin
        illegal_flag <= 1'b1;
      end else if (wr_status && dat_i[`DBMS_ST_ILLEGAL]) begin
        illegal_flag <= 1'b0;
      end
      if (release_hit && (state == ST_ADDR || state == ST_DATA)) begin
        relseen_flag <= 1'b1;
      end else if (wr_status && dat_i[`DBMS_ST_RELSEEN]) begin
        relseen_flag <= 1'b0;
      end
      xfer_done <= (state == ST_DATA) && data_end;
      if ((state == ST_DATA) && data_end) begin
        xfer_count <= xfer_count + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // One wait state: ack one cycle after the strobe, unmapped reads zero
  always @(posedge core_clk) begin
    if (sys_rst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      bus_config_reg <= `DBMS_CFG_RESET;
    end else begin
      ack_o <= acc;
      if (wr_cfg) begin
        bus_config_reg <= dat_i[7:0] & `DBMS_CFG_WMASK;
      end
      if (acc && !we_i) begin
        case (adr_i)
          `DBMS_ADR_CONFIG: dat_o <= {24'h000000, bus_config_reg};
          `DBMS_ADR_STATUS: dat_o <= {28'h0000000, relseen_flag, illegal_flag,
                                      (state != ST_IDLE), (state == ST_ADDR) ||
                                      (state == ST_DATA)};
          `DBMS_ADR_COUNT: dat_o <= {16'h0000, xfer_count};
          default: dat_o <= 32'h00000000;
        endcase
      end else begin
        dat_o <= 32'h00000000;
      end
    end
  end

endmodule
`default_nettype wire

//--- dbms_defs.vh
`ifndef DBMS_DEFS_VH
`define DBMS_DEFS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define DBMS_ADR_CONFIG 8'h00
`define DBMS_ADR_STATUS 8'h04
`define DBMS_ADR_COUNT 8'h08

// ----------------------------------------------------------------
// Bus configuration register fields
// ----------------------------------------------------------------
`define DBMS_CFG_STYLE 0
`define DBMS_CFG_POL 1
`define DBMS_CFG_REL 6
`define DBMS_CFG_WMASK 8'h43
`define DBMS_CFG_RESET 8'h00

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define DBMS_ST_MASTER 0
`define DBMS_ST_REQ 1
`define DBMS_ST_ILLEGAL 2
`define DBMS_ST_RELSEEN 3

// ----------------------------------------------------------------
// Byte selection codes on the user side
// ----------------------------------------------------------------
`define DBMS_SEL_WORD 2'h0
`define DBMS_SEL_UPPER 2'h1
`define DBMS_SEL_LOWER 2'h2
`define DBMS_SEL_NONE 2'h3

// ----------------------------------------------------------------
// Phase lengths in core clock cycles
// ----------------------------------------------------------------
`define DBMS_ADDR_CYCLES 2'h1
`define DBMS_DATA_CYCLES 2'h2

`endif

//--- dbms_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbms_defs.vh"
// ----------------
// Pin checker
// ----------------
module dbms_chk (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic ack_o,
  input wire logic xfer_valid,
  input wire logic [1:0] xfer_byte_sel,
  input wire logic byte_mask_low_line,
  input wire logic byte_mask_low_line_oe,
  input wire logic burst_release_in,
  input wire logic byte_mask_high_line,
  input wire logic byte_mask_high_line_oe,
  input wire logic gated_bus_request_oe,
  input wire logic gated_bus_request_in,
  input wire logic hold_grant_in,
  input wire logic addr_strobe_low,
  input wire logic addr_strobe_low_oe
);
  logic sty;
  logic pol;
  logic rel;
  // Shadow config; lags the block by one edge, as do its registered pins
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {rel, pol, sty} <= 3'h0;
    end else if (cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i == `DBMS_ADR_CONFIG) begin
      {rel, pol, sty} <= {dat_i[6], dat_i[1], dat_i[0]};
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_strobe_needs_grant: assert property (addr_strobe_low_oe |->
    gated_bus_request_oe && !hold_grant_in) else $error("strobe driven without grant");
  a_mask_only_master: assert property (byte_mask_low_line_oe |->
    addr_strobe_low_oe && !rel) else $error("pin 15 driven out of turn");
  a_req_holds_txn: assert property ($fell(gated_bus_request_oe) |->
    $fell(addr_strobe_low_oe)) else $error("request dropped inside transfer");
  a_strobe_shape: assert property ($rose(addr_strobe_low_oe) |->
    addr_strobe_low == !pol ##1 (addr_strobe_low == pol)[*2]) else $error("strobe shape");
  a_mask_code: assert property (byte_mask_low_line_oe && !sty |->
    {byte_mask_high_line, byte_mask_low_line} == xfer_byte_sel) else $error("mask code");
  a_byte_line: assert property (byte_mask_low_line_oe && sty && xfer_byte_sel != 2'h3 |->
    byte_mask_low_line == (xfer_byte_sel != 2'h0)) else $error("byte line");
  a_grant_ack: assert property (sty && addr_strobe_low_oe |->
    byte_mask_high_line && byte_mask_high_line_oe) else $error("grant ack low");
  a_req_prompt: assert property ((hold_grant_in)[*5] ##0
    (!sty && $rose(xfer_valid) && !gated_bus_request_oe) |=> gated_bus_request_oe)
    else $error("request late");
  a_req_prior_low: assert property ((sty && !gated_bus_request_in &&
    !gated_bus_request_oe)[*3] |=> !gated_bus_request_oe) else $error("request on low pin");
  a_grant_to_addr: assert property ($fell(hold_grant_in) && gated_bus_request_oe |->
    ##[1:5] addr_strobe_low_oe) else $error("no address phase");
  a_release_ends: assert property (rel && $rose(burst_release_in) |->
    ##[1:12] !addr_strobe_low_oe) else $error("burst not ended");
endmodule
bind dbms_top dbms_chk u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .ack_o(ack_o), .xfer_valid(xfer_valid),
  .xfer_byte_sel(xfer_byte_sel), .byte_mask_low_line(byte_mask_low_line),
  .byte_mask_low_line_oe(byte_mask_low_line_oe), .burst_release_in(burst_release_in),
  .byte_mask_high_line(byte_mask_high_line), .byte_mask_high_line_oe(byte_mask_high_line_oe),
  .gated_bus_request_oe(gated_bus_request_oe), .gated_bus_request_in(gated_bus_request_in),
  .hold_grant_in(hold_grant_in), .addr_strobe_low(addr_strobe_low),
  .addr_strobe_low_oe(addr_strobe_low_oe)
);
`default_nettype wire

//--- dbms_arb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// Host bus arbiter
// ----------------
module dbms_arb (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic req_n,
  input wire logic [3:0] lag,
  output logic grant_n
);
  logic [3:0] cnt;
  // grant follows the request after lag cycles, so never withdrawn while requested
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      grant_n <= 1'b1;
      cnt <= 4'h0;
    end else if (req_n != grant_n && cnt >= lag) begin
      grant_n <= req_n;
      cnt <= 4'h0;
    end else begin
      cnt <= (req_n != grant_n) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

//--- test_dma_bus_master_signalling.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// Testbench
// ----------------
module test_dma_bus_master_signalling;
  logic core_clk, sys_rst, cyc_i, stb_i, we_i, ack_o, xfer_valid, xfer_more, xfer_addr0;
  logic xfer_done, byte_mask_low_line, byte_mask_low_line_oe, burst_release_in, ext_low;
  logic byte_mask_high_line, byte_mask_high_line_oe, gated_bus_request, gated_bus_request_oe;
  logic hold_grant_in, addr_strobe_low, addr_strobe_low_oe;
  logic [7:0] adr_i;
  logic [31:0] dat_i, dat_o, q;
  logic [3:0] sel_i, lag;
  logic [1:0] xfer_byte_sel;
  int err_count, cmp_count, ticks;
  dbms_top u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
    .xfer_valid(xfer_valid), .xfer_more(xfer_more), .xfer_byte_sel(xfer_byte_sel),
    .xfer_addr0(xfer_addr0), .xfer_done(xfer_done), .byte_mask_low_line(byte_mask_low_line),
    .byte_mask_low_line_oe(byte_mask_low_line_oe), .burst_release_in(burst_release_in),
    .byte_mask_high_line(byte_mask_high_line), .byte_mask_high_line_oe(byte_mask_high_line_oe),
    .gated_bus_request(gated_bus_request), .gated_bus_request_oe(gated_bus_request_oe),
    .gated_bus_request_in(~(gated_bus_request_oe | ext_low)), .hold_grant_in(hold_grant_in),
    .addr_strobe_low(addr_strobe_low), .addr_strobe_low_oe(addr_strobe_low_oe)
  );
  // Arbiter sees only our drive, so a foreign pull-down tests the prior-state check alone
  dbms_arb u_arb (.core_clk(core_clk), .sys_rst(sys_rst), .req_n(~gated_bus_request_oe),
    .lag(lag), .grant_n(hold_grant_in));
  // 40 MHz clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    ticks++;
    if (ticks == 3000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
    @(posedge core_clk);
    while (ack_o !== 1'b1) @(posedge core_clk);
    q = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic xfer(input logic [1:0] s, input logic a0, input logic [1:0] e, input logic p);
    xfer_byte_sel <= s; xfer_addr0 <= a0; xfer_valid <= 1'b1;
    while (addr_strobe_low_oe !== 1'b1) @(posedge core_clk);
    chk({gated_bus_request_oe, gated_bus_request, byte_mask_high_line_oe, byte_mask_low_line_oe,
         byte_mask_high_line, byte_mask_low_line, addr_strobe_low}, {4'hb, e, ~p});
    while (xfer_done !== 1'b1) @(posedge core_clk);
    xfer_valid <= 1'b0;
    @(posedge core_clk);
  endtask
  // Wait until the grant is back and the sequencer has left its release state
  task automatic settle;
    while (hold_grant_in !== 1'b1) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
  endtask
  task end_sim;
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {cyc_i, stb_i, we_i, xfer_valid, xfer_more, xfer_addr0, burst_release_in, ext_low} = 8'h0;
    adr_i = 8'h0; dat_i = 32'h0; sel_i = 4'hf; lag = 4'h0; xfer_byte_sel = 2'h0; sys_rst = 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    wb(1'b0, 8'h00, 32'h0); chk(q, 32'h0);
    wb(1'b1, 8'h00, 32'hff);
    sel_i <= 4'he;
    wb(1'b1, 8'h00, 32'h0);
    sel_i <= 4'hf;
    wb(1'b0, 8'h00, 32'h0); chk(q, 32'h43);
    wb(1'b0, 8'h0c, 32'h0); chk(q, 32'h0);
    wb(1'b1, 8'h00, 32'h0);
    ext_low <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      xfer(i[1:0], 1'b0, i[1:0], 1'b0);
      ext_low <= 1'b0;
      lag <= 4'h6;
    end
    wb(1'b1, 8'h00, 32'h3);
    for (int i = 0; i < 3; i++) begin
      xfer(i[1:0], i == 1, {1'b1, i != 0}, 1'b1);
    end
    xfer(2'h0, 1'b1, 2'h2, 1'b1);
    wb(1'b0, 8'h04, 32'h0); chk(q[2], 1'b1);
    wb(1'b1, 8'h04, 32'h4);
    settle();
    wb(1'b0, 8'h04, 32'h0); chk(q[3:0], 4'h0);
    // Pin must read low through the synchroniser before the need arises
    ext_low <= 1'b1;
    repeat (3) @(posedge core_clk);
    xfer_valid <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk(gated_bus_request_oe, 1'b0);
    ext_low <= 1'b0;
    xfer(2'h1, 1'b1, 2'h3, 1'b1);
    wb(1'b0, 8'h08, 32'h0); chk(q, 32'h9);
    wb(1'b1, 8'h00, 32'h40);
    lag <= 4'h0;
    xfer_more <= 1'b1;
    xfer_valid <= 1'b1;
    while (addr_strobe_low_oe !== 1'b1) @(posedge core_clk);
    chk(byte_mask_low_line_oe, 1'b0);
    burst_release_in <= 1'b1;
    while (gated_bus_request_oe !== 1'b0) @(posedge core_clk);
    {xfer_valid, xfer_more, burst_release_in} <= 3'h0;
    wb(1'b0, 8'h08, 32'h0); chk(q, 32'hb);
    settle();
    wb(1'b0, 8'h04, 32'h0); chk(q[3:0], 4'h8);
    end_sim();
  end
endmodule
`default_nettype wire
